// >>> core/display_irq_ctrl.sv
`timescale 1ns/1ps

// Overview of operation
// - Set mask suppresses its source regardless of enable.
// - Clear mask and set enable pass source.
// - Enables for master, video, draw at 6:4.
// - Masks for master, video, draw at 2:0.
// - Enable/mask at index 19h, RW, resets zero.
// - Status bits 0,1,2,4 report detected sources.
// - VGA status gated inside VGA block only.
// - Source status at 1Ah, read-only, reserved zero.
// - User-pin status at 1Ch, bits 3:0.
// - Bits 7:4 of 1Fh enable pin interrupts.
// - Bits 3:0 of 1Fh mask pin interrupts.
module display_irq_ctrl (
  input  wire logic                   I_CLOCK,     // System clock, 40 MHz.
  input  wire logic                   I_SYS_RST,   // Synchronous reset, active high.
  input  wire logic [15:0]            I_IO_ADDR,   // Host I/O address.
  input  wire logic                   I_IO_WR,     // Host I/O write strobe.
  input  wire logic                   I_IO_RD,     // Host I/O read strobe.
  input  wire logic [7:0]             I_IO_WDATA,  // Host I/O write data.
  input  wire irq_ctrl_pkg::irq_core_t I_CORE_IRQ, // Master, video, draw conditions.
  input  wire logic                   I_VGA_IRQ,   // VGA condition, already gated.
  input  wire logic [3:0]             I_USER_PIN,  // User pin levels.
  output logic [7:0]                  O_IO_RDATA,  // Read data, registered.
  output logic                        O_IO_RVALID, // Read answer pulse, registered.
  output logic                        O_IRQ        // Interrupt request, registered.
);

  localparam int UP = irq_ctrl_pkg::USER_PINS;

  logic [7:0] index_q;
  logic [7:0] index_d;
  logic [7:0] en_mask_q;
  logic [7:0] en_mask_d;
  logic [7:0] user_ctrl_q;
  logic [7:0] user_ctrl_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       rvalid_q;
  logic       rvalid_d;
  logic       irq_q;
  logic       irq_d;
  logic       vga_st_q;
  logic       vga_st_d;

  logic                     index_wr;
  logic                     data_wr;
  logic                     data_rd;
  logic [irq_ctrl_pkg::CORE_SOURCES-1:0] core_en;
  logic [irq_ctrl_pkg::CORE_SOURCES-1:0] core_mask;
  irq_ctrl_pkg::irq_core_t  core_status;
  logic                     core_pend;
  logic [UP-1:0]            user_hw_en;
  logic [UP-1:0]            user_mask;
  logic [UP-1:0]            user_raw;
  logic [UP-1:0]            user_status;
  logic                     user_pend;

  // Host access decode: the index port selects, the data port reads or writes.
  assign index_wr = I_IO_WR && (I_IO_ADDR == irq_ctrl_pkg::IO_INDEX_ADDR);
  assign data_wr  = I_IO_WR && (I_IO_ADDR == irq_ctrl_pkg::IO_DATA_ADDR);
  assign data_rd  = I_IO_RD && (I_IO_ADDR == irq_ctrl_pkg::IO_DATA_ADDR);

  // Enable and mask fields of the shared register, in status bit order.
  assign core_en[irq_ctrl_pkg::ST_BUS_MASTER_BIT]  =
    en_mask_q[irq_ctrl_pkg::EN_BUS_MASTER_BIT];
  assign core_en[irq_ctrl_pkg::ST_VIDEO_IN_BIT]    =
    en_mask_q[irq_ctrl_pkg::EN_VIDEO_IN_BIT];
  assign core_en[irq_ctrl_pkg::ST_DRAW_ENGINE_BIT] =
    en_mask_q[irq_ctrl_pkg::EN_DRAW_ENGINE_BIT];
  assign core_mask[irq_ctrl_pkg::ST_BUS_MASTER_BIT]  =
    en_mask_q[irq_ctrl_pkg::MASK_BUS_MASTER_BIT];
  assign core_mask[irq_ctrl_pkg::ST_VIDEO_IN_BIT]    =
    en_mask_q[irq_ctrl_pkg::MASK_VIDEO_IN_BIT];
  assign core_mask[irq_ctrl_pkg::ST_DRAW_ENGINE_BIT] =
    en_mask_q[irq_ctrl_pkg::MASK_DRAW_ENG_BIT];

  // User pin fields; a pin not enabled as an interrupt input is ignored entirely.
  assign user_hw_en = user_ctrl_q[irq_ctrl_pkg::USER_EN_LSB +: UP];
  assign user_mask  = user_ctrl_q[irq_ctrl_pkg::USER_MASK_LSB +: UP];
  assign user_raw   = I_USER_PIN & user_hw_en;

  irq_gate #(
    .N (irq_ctrl_pkg::CORE_SOURCES)
  ) u_core_gate (
    .i_clk    (I_CLOCK),
    .i_rst    (I_SYS_RST),
    .i_raw    (I_CORE_IRQ),
    .i_en     (core_en),
    .i_mask   (core_mask),
    .o_status (core_status),
    .o_pend   (core_pend)
  );

  irq_gate #(
    .N (UP)
  ) u_user_gate (
    .i_clk    (I_CLOCK),
    .i_rst    (I_SYS_RST),
    .i_raw    (user_raw),
    .i_en     (user_hw_en),
    .i_mask   (user_mask),
    .o_status (user_status),
    .o_pend   (user_pend)
  );

  // Register writes; reserved bits of the enable/mask register never store.
  always_comb begin
    index_d     = index_q;
    en_mask_d   = en_mask_q;
    user_ctrl_d = user_ctrl_q;
    if (index_wr) begin
      index_d = I_IO_WDATA;
    end
    if (data_wr && (index_q == irq_ctrl_pkg::IDX_ENABLE_MASK)) begin
      en_mask_d = I_IO_WDATA & irq_ctrl_pkg::ENABLE_MASK_WMASK;
    end
    if (data_wr && (index_q == irq_ctrl_pkg::IDX_USER_CTRL)) begin
      user_ctrl_d = I_IO_WDATA;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      index_q     <= irq_ctrl_pkg::INDEX_RST;
      en_mask_q   <= irq_ctrl_pkg::ENABLE_MASK_RST;
      user_ctrl_q <= irq_ctrl_pkg::USER_CTRL_RST;
    end else begin
      index_q     <= index_d;
      en_mask_q   <= en_mask_d;
      user_ctrl_q <= user_ctrl_d;
    end
  end

  // Register reads; an index outside this block answers nothing and leaves data idle.
  always_comb begin
    rdata_d  = irq_ctrl_pkg::READ_IDLE;
    rvalid_d = 1'b0;
    if (data_rd) begin
      case (index_q)
        irq_ctrl_pkg::IDX_ENABLE_MASK: begin
          rdata_d  = en_mask_q;
          rvalid_d = 1'b1;
        end
        irq_ctrl_pkg::IDX_SOURCE_STATUS: begin
          rdata_d[irq_ctrl_pkg::ST_DRAW_ENGINE_BIT] = core_status.draw_engine;
          rdata_d[irq_ctrl_pkg::ST_VIDEO_IN_BIT]    = core_status.video_in;
          rdata_d[irq_ctrl_pkg::ST_BUS_MASTER_BIT]  = core_status.bus_master;
          rdata_d[irq_ctrl_pkg::ST_VGA_BIT]         = vga_st_q;
          rvalid_d = 1'b1;
        end
        irq_ctrl_pkg::IDX_USER_STATUS: begin
          rdata_d[UP-1:0] = user_status;
          rvalid_d        = 1'b1;
        end
        irq_ctrl_pkg::IDX_USER_CTRL: begin
          rdata_d  = user_ctrl_q;
          rvalid_d = 1'b1;
        end
        default: begin
          rdata_d  = irq_ctrl_pkg::READ_IDLE;
          rvalid_d = 1'b0;
        end
      endcase
    end
  end

  // The VGA condition arrives already gated, so only its status is kept here.
  always_comb begin
    vga_st_d = I_VGA_IRQ;
    irq_d    = core_pend | user_pend | vga_st_q;
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      rdata_q  <= irq_ctrl_pkg::READ_IDLE;
      rvalid_q <= 1'b0;
      vga_st_q <= 1'b0;
      irq_q    <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
      vga_st_q <= vga_st_d;
      irq_q    <= irq_d;
    end
  end

  assign O_IO_RDATA  = rdata_q;
  assign O_IO_RVALID = rvalid_q;
  assign O_IRQ       = irq_q;

  // Checks below watch only what this block drives.
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_SYS_RST);

  // A raw condition takes two edges to reach the request: status, then request.
  sequence s_draw_live;
    I_CORE_IRQ.draw_engine && en_mask_q[irq_ctrl_pkg::EN_DRAW_ENGINE_BIT]
      && !en_mask_q[irq_ctrl_pkg::MASK_DRAW_ENG_BIT];
  endsequence

  // The enable/mask value must still hold at the status edge, or the gate sees a new setting.
  sequence s_draw_stays;
    $stable(en_mask_q);
  endsequence

  a_mask_blocks_src: assert property (
    (en_mask_q == irq_ctrl_pkg::ENABLE_MASK_WMASK) && !vga_st_q && !user_pend
      ##1 (en_mask_q == irq_ctrl_pkg::ENABLE_MASK_WMASK) && !vga_st_q && !user_pend
      |-> !O_IRQ)
    else $error("masked sources raised the request");

  a_enable_fires_src: assert property (
    s_draw_live ##1 s_draw_stays |=> O_IRQ)
    else $error("enabled unmasked source did not raise the request");

  a_enable_field_pos: assert property (
    data_wr && (index_q == irq_ctrl_pkg::IDX_ENABLE_MASK)
      |=> core_en == $past(I_IO_WDATA[irq_ctrl_pkg::EN_BUS_MASTER_BIT -: 3]))
    else $error("enable fields not at bits 6 to 4");

  a_mask_field_pos: assert property (
    data_wr && (index_q == irq_ctrl_pkg::IDX_ENABLE_MASK)
      |=> core_mask == $past(I_IO_WDATA[irq_ctrl_pkg::MASK_BUS_MASTER_BIT -: 3]))
    else $error("mask fields not at bits 2 to 0");

  a_enmask_readback: assert property (
    data_rd && (index_q == irq_ctrl_pkg::IDX_ENABLE_MASK)
      |=> O_IO_RVALID && (O_IO_RDATA == $past(en_mask_q))
        && ((O_IO_RDATA & ~irq_ctrl_pkg::ENABLE_MASK_WMASK) == 8'h00))
    else $error("enable/mask readback wrong");

  a_status_tracks_src: assert property (
    ##1 data_rd && (index_q == irq_ctrl_pkg::IDX_SOURCE_STATUS)
      |=> O_IO_RDATA[irq_ctrl_pkg::ST_BUS_MASTER_BIT] == $past(I_CORE_IRQ.bus_master, 2))
    else $error("bus master status does not follow its source");

  a_vga_path_only: assert property (
    $past(I_VGA_IRQ, 2) |-> O_IRQ)
    else $error("VGA condition did not reach the request");

  a_status_reserved: assert property (
    data_rd && (index_q == irq_ctrl_pkg::IDX_SOURCE_STATUS)
      |=> (O_IO_RDATA[7:5] == 3'h0) && !O_IO_RDATA[3])
    else $error("reserved status bits not zero");

  a_user_status_rd: assert property (
    data_rd && (index_q == irq_ctrl_pkg::IDX_USER_STATUS)
      |=> (O_IO_RDATA[7:4] == 4'h0) && (O_IO_RDATA[3:0] == $past(user_status)))
    else $error("user pin status readback wrong");

  a_user_pin_off: assert property (
    !user_hw_en[0] |=> !user_status[0])
    else $error("disabled user pin produced status");

  a_user_mask_blocks: assert property (
    (user_mask == 4'hF) |-> !u_user_gate.o_pend)
    else $error("masked user pins raised a pending request");

  a_request_quiet: assert property (
    !core_pend && !user_pend && !vga_st_q |=> !O_IRQ)
    else $error("request raised with no pending source");

  a_status_holds: assert property (
    I_CORE_IRQ.video_in [*2] |-> ##1 core_status.video_in)
    else $error("status dropped while the source still holds it");

endmodule // display_irq_ctrl

// >>> core/irq_ctrl_pkg.sv
package irq_ctrl_pkg;

  // Host I/O ports of the indexed sequencer register space.
  localparam logic [15:0] IO_INDEX_ADDR = 16'h03C4;
  localparam logic [15:0] IO_DATA_ADDR  = 16'h03C5;

  // Indices of the interrupt registers.
  localparam logic [7:0] IDX_ENABLE_MASK    = 8'h19;
  localparam logic [7:0] IDX_SOURCE_STATUS  = 8'h1A;
  localparam logic [7:0] IDX_USER_STATUS    = 8'h1C;
  localparam logic [7:0] IDX_USER_CTRL      = 8'h1F;

  // Reset values.
  localparam logic [7:0] ENABLE_MASK_RST    = 8'h00;
  localparam logic [7:0] USER_CTRL_RST      = 8'h00;
  localparam logic [7:0] INDEX_RST          = 8'h00;
  localparam logic [7:0] READ_IDLE          = 8'h00;

  // Writable bits of the enable/mask register; bits 7 and 3 are reserved.
  localparam logic [7:0] ENABLE_MASK_WMASK  = 8'h77;

  // Field positions of the enable/mask register.
  localparam int EN_BUS_MASTER_BIT   = 6;
  localparam int EN_VIDEO_IN_BIT     = 5;
  localparam int EN_DRAW_ENGINE_BIT  = 4;
  localparam int MASK_BUS_MASTER_BIT = 2;
  localparam int MASK_VIDEO_IN_BIT   = 1;
  localparam int MASK_DRAW_ENG_BIT   = 0;

  // Field positions of the source status register.
  localparam int ST_DRAW_ENGINE_BIT  = 0;
  localparam int ST_VIDEO_IN_BIT     = 1;
  localparam int ST_BUS_MASTER_BIT   = 2;
  localparam int ST_VGA_BIT          = 4;

  // User pins and the layout of the user-pin control register.
  localparam int USER_PINS           = 4;
  localparam int USER_EN_LSB         = 4;
  localparam int USER_MASK_LSB       = 0;
  localparam int CORE_SOURCES        = 3;

  // Core interrupt sources, ordered as in the status register.
  typedef struct packed {
    logic bus_master;
    logic video_in;
    logic draw_engine;
  } irq_core_t;

endpackage

// >>> core/irq_gate.sv
`timescale 1ns/1ps

// Registers a group of raw source conditions as status and gates them.
module irq_gate #(
  parameter int N = 3
) (
  input  wire logic         i_clk,    // System clock.
  input  wire logic         i_rst,    // Synchronous reset, active high.
  input  wire logic [N-1:0] i_raw,    // Raw source conditions, level.
  input  wire logic [N-1:0] i_en,     // Per-source enables.
  input  wire logic [N-1:0] i_mask,   // Per-source masks.
  output logic      [N-1:0] o_status, // Registered status.
  output logic              o_pend    // Any enabled, unmasked status.
);

  logic [N-1:0] status_q;
  logic [N-1:0] status_d;
  logic [N-1:0] gated;

  if (N < 1) begin : g_bad_n
    $error("irq_gate needs at least one source");
  end

  // Status simply follows the source level, so it stays set until the unit withdraws it.
  always_comb begin
    status_d = i_raw;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  // One gate per source: the mask wins over the enable.
  for (genvar g = 0; g < N; g++) begin : g_src
    assign gated[g] = status_q[g] & i_en[g] & ~i_mask[g];
  end

  assign o_status = status_q;
  assign o_pend   = |gated;

endmodule // irq_gate

// >>> test/host_model.sv
`timescale 1ns/1ps

// Host processor model: reaches the indexed registers through the index and data ports.
module host_model (
  input  wire logic        i_clk,    // System clock.
  input  wire logic [7:0]  i_rdata,  // Read data from the device.
  input  wire logic        i_rvalid, // Read answer pulse.
  output logic      [15:0] o_addr,   // I/O address.
  output logic             o_wr,     // Write strobe.
  output logic             o_rd,     // Read strobe.
  output logic      [7:0]  o_wdata   // Write data.
);
  // The bus starts idle before the first falling edge.
  initial begin
    o_addr  = 16'h0000;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_wdata = 8'h00;
  end

  // One bus cycle per falling edge, so nothing moves near the sampling edge.
  task automatic cycle(input logic [15:0] a, input logic w, input logic r, input logic [7:0] d);
    @(negedge i_clk);
    o_addr  = a;
    o_wr    = w;
    o_rd    = r;
    o_wdata = d;
  endtask

  // Idle data is inverted so the device cannot profit from a stale write value.
  task automatic idle();
    cycle(16'h0000, 1'b0, 1'b0, ~o_wdata);
  endtask

  // Index write, then data write, then release.
  task automatic write_reg(input logic [7:0] idx, input logic [7:0] d);
    cycle(irq_ctrl_pkg::IO_INDEX_ADDR, 1'b1, 1'b0, idx);
    cycle(irq_ctrl_pkg::IO_DATA_ADDR, 1'b1, 1'b0, d);
    idle();
  endtask

  // Index write, data read, then a bounded wait for the one-cycle answer.
  task automatic read_reg(input logic [7:0] idx, output logic [7:0] d, output logic ok);
    int n;
    cycle(irq_ctrl_pkg::IO_INDEX_ADDR, 1'b1, 1'b0, idx);
    cycle(irq_ctrl_pkg::IO_DATA_ADDR, 1'b0, 1'b1, ~idx);
    idle();
    ok = 1'b0;
    d  = i_rdata;
    for (n = 0; n < 3 && !ok; n++) begin
      if (i_rvalid === 1'b1) begin
        ok = 1'b1;
        d  = i_rdata;
      end else begin
        @(negedge i_clk);
      end
    end
  endtask
endmodule // host_model

// >>> test/display_interrupt_control_test.sv
`timescale 1ns/1ps

// Self-checking bench: random and corner settings of enables, masks and sources.
module display_interrupt_control_test;
  logic                    clk;
  logic                    sys_rst;
  logic [15:0]             io_addr;
  logic                    io_wr;
  logic                    io_rd;
  logic [7:0]              io_wdata;
  irq_ctrl_pkg::irq_core_t core_irq;
  logic                    vga_irq;
  logic [3:0]              user_pin;
  logic [7:0]              io_rdata;
  logic                    io_rvalid;
  logic                    irq;
  int                      mismatches;
  int                      check_count;
  int                      seed;
  int                      i;
  logic [7:0]              em;
  logic [7:0]              uc;
  logic [7:0]              d;
  logic                    ok;
  logic [7:0]              corner_em [4] = '{8'h77, 8'h70, 8'h07, 8'h00};
  logic [7:0]              corner_uc [4] = '{8'hFF, 8'hF0, 8'h0F, 8'h00};

  display_irq_ctrl display_irq_ctrl_inst (
    .I_CLOCK     (clk),
    .I_SYS_RST   (sys_rst),
    .I_IO_ADDR   (io_addr),
    .I_IO_WR     (io_wr),
    .I_IO_RD     (io_rd),
    .I_IO_WDATA  (io_wdata),
    .I_CORE_IRQ  (core_irq),
    .I_VGA_IRQ   (vga_irq),
    .I_USER_PIN  (user_pin),
    .O_IO_RDATA  (io_rdata),
    .O_IO_RVALID (io_rvalid),
    .O_IRQ       (irq)
  );

  host_model host_model_inst (
    .i_clk    (clk),
    .i_rdata  (io_rdata),
    .i_rvalid (io_rvalid),
    .o_addr   (io_addr),
    .o_wr     (io_wr),
    .o_rd     (io_rd),
    .o_wdata  (io_wdata)
  );

  // A 25 ns period for the 40 MHz system clock.
  always begin
    #12.5 clk = ~clk;
  end

  // Expected request: gated core sources, the pre-gated VGA source and gated user pins.
  function automatic logic exp_irq(logic [7:0] e, logic [7:0] u, logic [2:0] c, logic v,
                                   logic [3:0] p);
    return (|(c & e[6:4] & ~e[2:0])) | v | (|(p & u[7:4] & ~u[3:0]));
  endfunction

  // Counts every comparison and reports a mismatch at once.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Register read that must be answered; a missing answer ends the run.
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input string what);
    host_model_inst.read_reg(idx, d, ok);
    if (ok !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: no read answer for %s", $time, what);
      close_out();
    end else begin
      check(d, exp, what);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence: reset values, refusals, gating table, then exact timing.
  initial begin
    clk         = 1'b0;
    sys_rst     = 1'b1;
    core_irq    = '0;
    vga_irq     = 1'b0;
    user_pin    = 4'h0;
    mismatches  = 0;
    check_count = 0;
    seed        = 32'hEA338773;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    rd_chk(irq_ctrl_pkg::IDX_ENABLE_MASK, 8'h00, "enable mask reset");
    rd_chk(irq_ctrl_pkg::IDX_USER_CTRL, 8'h00, "user control reset");
    host_model_inst.read_reg(8'h20, d, ok);
    check({7'h00, ok}, 8'h00, "unmapped index answered");
    check(d, 8'h00, "unmapped index data");
    $display("test reset and refusal done");
    for (i = 0; i < 40; i++) begin
      if (i < 4) begin
        em = corner_em[i];
        uc = corner_uc[i];
      end else begin
        em = 8'($random(seed));
        uc = 8'($random(seed));
      end
      host_model_inst.write_reg(irq_ctrl_pkg::IDX_ENABLE_MASK, em);
      host_model_inst.write_reg(irq_ctrl_pkg::IDX_USER_CTRL, uc);
      host_model_inst.write_reg(irq_ctrl_pkg::IDX_SOURCE_STATUS, 8'hFF);
      @(negedge clk);
      core_irq = (i < 4) ? 3'h7 : 3'($random(seed));
      vga_irq  = (i < 4) ? 1'b0 : 1'($random(seed));
      user_pin = (i < 4) ? 4'hF : 4'($random(seed));
      repeat (2) @(negedge clk);
      check({7'h00, irq}, {7'h00, exp_irq(em, uc, core_irq, vga_irq, user_pin)},
            "request");
      rd_chk(irq_ctrl_pkg::IDX_ENABLE_MASK, em & 8'h77, "enable mask");
      rd_chk(irq_ctrl_pkg::IDX_USER_CTRL, uc, "user control");
      rd_chk(irq_ctrl_pkg::IDX_SOURCE_STATUS, {3'h0, vga_irq, 1'b0, core_irq},
             "source status");
      rd_chk(irq_ctrl_pkg::IDX_USER_STATUS, {4'h0, user_pin & uc[7:4]},
             "user status");
    end
    $display("test gating table done");
    host_model_inst.write_reg(irq_ctrl_pkg::IDX_ENABLE_MASK, 8'h10);
    core_irq = '0;
    vga_irq  = 1'b0;
    user_pin = 4'h0;
    repeat (3) @(negedge clk);
    core_irq.draw_engine = 1'b1;
    @(negedge clk);
    check({7'h00, irq}, 8'h00, "request too early");
    @(negedge clk);
    check({7'h00, irq}, 8'h01, "request rise");
    repeat (5) @(negedge clk);
    check({7'h00, irq}, 8'h01, "request held");
    core_irq.draw_engine = 1'b0;
    @(negedge clk);
    check({7'h00, irq}, 8'h01, "request drop too early");
    @(negedge clk);
    check({7'h00, irq}, 8'h00, "request drop");
    $display("test request timing done");
    close_out();
  end
endmodule // display_interrupt_control_test
